/* hw/pmr_regs.sv */
// AXI4-Lite slave with the power enable, soft reset and family code registers
`include "pmr_params.svh"
`default_nettype none
module pmr_regs #(
    // Value is arbitrary, not a real part code
    parameter pmr_pkg::pmr_word_t FAMILY_CODE = `PMR_FAMILY_DEF
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // Write address channel
    input wire logic [`PMR_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // Write data channel
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // Write response channel
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // Read address channel
    input wire logic [`PMR_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // Read data channel
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Enable levels to the analogue and clock functions
    output var pmr_pkg::pmr_enables_s enables
);
    pmr_pkg::pmr_slave_s st;
    pmr_pkg::pmr_slave_s next_st;

    logic pair_valid;
    logic [`PMR_ADDR_W-1:0] pair_addr;
    logic [31:0] pair_data;
    logic [3:0] pair_strb;
    logic commit;
    logic [`PMR_IDX_W-1:0] wr_idx;
    logic [`PMR_IDX_W-1:0] rd_idx;
    logic wr_bias;
    logic wr_func;
    logic soft_clr;
    logic ar_take;
    pmr_pkg::pmr_word_t bias_value;
    pmr_pkg::pmr_word_t func_value;

    function automatic logic [`PMR_IDX_W-1:0] idx_of(input logic [`PMR_ADDR_W-1:0] addr);
        return addr[`PMR_ADDR_W-1:2];
    endfunction

    function automatic logic is_mapped(input logic [`PMR_IDX_W-1:0] idx);
        return (idx == `PMR_IDX_RESET_AND_IDENTITY) || (idx == `PMR_IDX_BIAS) ||
               (idx == `PMR_IDX_FUNC);
    endfunction

    function automatic pmr_pkg::pmr_word_t read_word(input logic [`PMR_IDX_W-1:0] idx,
                                                     input pmr_pkg::pmr_word_t bias,
                                                     input pmr_pkg::pmr_word_t func);
        pmr_pkg::pmr_word_t res;
        res = '0;
        case (idx)
            `PMR_IDX_RESET_AND_IDENTITY: res = FAMILY_CODE;
            `PMR_IDX_BIAS: res = bias;
            `PMR_IDX_FUNC: res = func;
            default: res = '0;
        endcase
        return res;
    endfunction

    pmr_wr_join u_join (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .awaddr(s_axi_awaddr),
        .awvalid(s_axi_awvalid),
        .awready(s_axi_awready),
        .wdata(s_axi_wdata),
        .wstrb(s_axi_wstrb),
        .wvalid(s_axi_wvalid),
        .wready(s_axi_wready),
        .pair_valid(pair_valid),
        .pair_addr(pair_addr),
        .pair_data(pair_data),
        .pair_strb(pair_strb),
        .pop(commit)
    );

    // A joined write commits only while no response is waiting
    assign commit = pair_valid && !st.bvalid;
    assign wr_idx = idx_of(pair_addr);
    assign rd_idx = idx_of(s_axi_araddr);
    // address selects register, low 16 data bits land in it
    assign wr_bias = commit && (wr_idx == `PMR_IDX_BIAS);
    assign wr_func = commit && (wr_idx == `PMR_IDX_FUNC);
    // any write to index zero, data ignored
    assign soft_clr = commit && (wr_idx == `PMR_IDX_RESET_AND_IDENTITY);
    assign ar_take = s_axi_arvalid && st.arready;

    // mic bias, divider and reference bits
    pmr_ctrl_reg #(
        .MASK(`PMR_BIAS_MASK)
    ) u_bias (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .wr_en(wr_bias),
        .soft_clr(soft_clr),
        .wdata(pair_data[`PMR_REG_W-1:0]),
        .wstrb(pair_strb[1:0]),
        .value(bias_value)
    );

    pmr_ctrl_reg #(
        .MASK(`PMR_FUNC_MASK)
    ) u_func (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .wr_en(wr_func),
        .soft_clr(soft_clr),
        .wdata(pair_data[`PMR_REG_W-1:0]),
        .wstrb(pair_strb[1:0]),
        .value(func_value)
    );

    always_comb begin
        next_st = st;
        if (commit) begin
            next_st.bvalid = 1'b1;
            next_st.bresp = is_mapped(wr_idx) ? `PMR_RESP_OKAY : `PMR_RESP_DECERR;
        end else if (st.bvalid && s_axi_bready) begin
            next_st.bvalid = 1'b0;
        end
        if (ar_take) begin
            next_st.arready = 1'b0;
            next_st.rvalid = 1'b1;
            // index zero reads the family code
            next_st.rdata = {16'h0000, read_word(rd_idx, bias_value, func_value)};
            next_st.rresp = is_mapped(rd_idx) ? `PMR_RESP_OKAY : `PMR_RESP_DECERR;
        end else if (st.rvalid && s_axi_rready) begin
            next_st.rvalid = 1'b0;
            next_st.arready = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            st <= '0;
            st.arready <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign s_axi_bresp = st.bresp;
    assign s_axi_bvalid = st.bvalid;
    assign s_axi_arready = st.arready;
    assign s_axi_rdata = st.rdata;
    assign s_axi_rresp = st.rresp;
    assign s_axi_rvalid = st.rvalid;

    assign enables.mic_bias_on = bias_value[`PMR_BIT_MIC];
    assign enables.mid_rail_sel = bias_value[`PMR_MID_HI:`PMR_MID_LO];
    assign enables.ref_bias_on = bias_value[`PMR_BIT_REF];
    assign enables.pll_on = func_value[`PMR_BIT_PLL];
    assign enables.left_converter_on = func_value[`PMR_BIT_LCONV];
    assign enables.right_converter_on = func_value[`PMR_BIT_RCONV];
    assign enables.thermal_sensor_on = func_value[`PMR_BIT_THERM];
    assign enables.clock_out_on = func_value[`PMR_BIT_CLKOUT];
    assign enables.left_path_on = func_value[`PMR_BIT_LPATH];
    assign enables.right_path_on = func_value[`PMR_BIT_RPATH];
    assign enables.left_pair_b_gain_on = func_value[`PMR_BIT_LGAIN_B];
    assign enables.left_pair_a_gain_on = func_value[`PMR_BIT_LGAIN_A];
    assign enables.right_pair_b_gain_on = func_value[`PMR_BIT_RGAIN_B];
    assign enables.right_pair_a_gain_on = func_value[`PMR_BIT_RGAIN_A];

    // Checks
    logic mic_req;
    logic [1:0] mid_req;
    logic ref_req;
    logic pll_req;
    logic therm_req;
    logic clk_req;
    logic [1:0] path_req;
    logic [3:0] gain_req;
    logic [1:0] conv_req;

    assign mic_req = pair_data[`PMR_BIT_MIC];
    assign mid_req = pair_data[`PMR_MID_HI:`PMR_MID_LO];
    assign ref_req = pair_data[`PMR_BIT_REF];
    assign pll_req = pair_data[`PMR_BIT_PLL];
    assign therm_req = pair_data[`PMR_BIT_THERM];
    assign clk_req = pair_data[`PMR_BIT_CLKOUT];
    assign path_req = pair_data[`PMR_BIT_LPATH:`PMR_BIT_RPATH];
    assign gain_req = pair_data[`PMR_BIT_LGAIN_B:`PMR_BIT_RGAIN_A];
    assign conv_req = pair_data[`PMR_BIT_LCONV:`PMR_BIT_RCONV];

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);

    mic_bias_write_a: assert property (
        wr_bias && pair_strb[0] |=> enables.mic_bias_on == $past(mic_req))
        else $error("mic bias enable did not follow write");

    mid_rail_write_a: assert property (
        wr_bias && pair_strb[0] |=> enables.mid_rail_sel == $past(mid_req))
        else $error("mid-rail select did not follow write");

    ref_bias_write_a: assert property (
        wr_bias && pair_strb[0] |=> enables.ref_bias_on == $past(ref_req))
        else $error("reference bias enable did not follow write");

    func_enable_write_a: assert property (
        wr_func && (pair_strb[1:0] == 2'h3) |=>
            enables.pll_on == $past(pll_req) &&
            {enables.left_converter_on, enables.right_converter_on} == $past(conv_req))
        else $error("pll or converter enable did not follow write");

    thermal_write_a: assert property (
        wr_func && pair_strb[1] |=> enables.thermal_sensor_on == $past(therm_req))
        else $error("thermal sensor enable did not follow write");

    clock_out_write_a: assert property (
        wr_func && pair_strb[1] |=> enables.clock_out_on == $past(clk_req))
        else $error("clock output enable did not follow write");

    path_write_a: assert property (
        wr_func && pair_strb[1] |=>
            {enables.left_path_on, enables.right_path_on} == $past(path_req))
        else $error("input path enables did not follow write");

    gain_write_a: assert property (
        wr_func && pair_strb[0] |=>
            {enables.left_pair_b_gain_on, enables.left_pair_a_gain_on,
             enables.right_pair_b_gain_on, enables.right_pair_a_gain_on} == $past(gain_req))
        else $error("gain stage enables did not follow write");

    soft_reset_a: assert property (
        soft_clr |=> enables == '0 && s_axi_bvalid && s_axi_bresp == `PMR_RESP_OKAY)
        else $error("write to index zero did not clear enables");

    family_read_a: assert property (
        ar_take && rd_idx == `PMR_IDX_RESET_AND_IDENTITY |=>
            s_axi_rvalid && s_axi_rdata == {16'h0000, FAMILY_CODE})
        else $error("index zero read did not return family code");

    func_readback_a: assert property (
        ar_take && rd_idx == `PMR_IDX_FUNC |=>
            s_axi_rdata == {16'h0000, $past(func_value)} && s_axi_rresp == `PMR_RESP_OKAY)
        else $error("function register read back wrong");

    enables_steady_a: assert property (
        !(wr_bias || wr_func || soft_clr) |=> $stable(enables))
        else $error("enable outputs changed without a write");

    write_resp_a: assert property (
        commit |=> s_axi_bvalid && s_axi_awready && s_axi_wready)
        else $error("write response not raised after commit");

    // Register content checks
    reset_default_a: assert property (
        $rose(nrst) |-> enables == '0 && s_axi_awready && s_axi_wready &&
            s_axi_arready && !s_axi_bvalid && !s_axi_rvalid)
        else $error("outputs not at defaults after reset");

    bias_mask_a: assert property (
        (bias_value & ~`PMR_BIAS_MASK) == 16'h0000)
        else $error("reserved bias bits stored");

    func_mask_a: assert property (
        (func_value & ~`PMR_FUNC_MASK) == 16'h0000)
        else $error("reserved function bits stored");

    soft_clear_regs_a: assert property (
        soft_clr |=> bias_value == 16'h0000 && func_value == 16'h0000)
        else $error("soft reset left a register set");

    bias_steady_a: assert property (
        !wr_bias && !soft_clr |=> $stable(bias_value))
        else $error("bias register changed without a write");

    func_steady_a: assert property (
        !wr_func && !soft_clr |=> $stable(func_value))
        else $error("function register changed without a write");

    lane_skip_a: assert property (
        (wr_bias || wr_func) && pair_strb[1:0] == 2'h0 |=> $stable(enables))
        else $error("write without low lanes changed enables");

    bias_readback_a: assert property (
        ar_take && rd_idx == `PMR_IDX_BIAS |=>
            s_axi_rdata == {16'h0000, $past(bias_value)} && s_axi_rresp == `PMR_RESP_OKAY)
        else $error("bias register read back wrong");

    family_resp_a: assert property (
        ar_take && rd_idx == `PMR_IDX_RESET_AND_IDENTITY |=>
            s_axi_rresp == `PMR_RESP_OKAY)
        else $error("family code read refused");

    // Bus handshake checks
    unmapped_read_a: assert property (
        ar_take && !is_mapped(rd_idx) |=>
            s_axi_rdata == 32'h0000_0000 && s_axi_rresp == `PMR_RESP_DECERR)
        else $error("unmapped read not refused");

    unmapped_write_a: assert property (
        commit && !is_mapped(wr_idx) |=>
            s_axi_bresp == `PMR_RESP_DECERR && $stable(enables))
        else $error("unmapped write not refused");

    read_answer_a: assert property (
        ar_take |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer not raised");

    read_release_a: assert property (
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
        else $error("read answer not released");

    write_release_a: assert property (
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response not released");

    aw_taken_a: assert property (
        s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
        else $error("write address ready stayed high");

    w_taken_a: assert property (
        s_axi_wvalid && s_axi_wready |=> !s_axi_wready)
        else $error("write data ready stayed high");
endmodule
`default_nettype wire

/* hw/pmr_params.svh */
// Offsets, field positions, reset values and bus codes of the power enable registers
// Behaviour
// - Bit 4 of bias register enables microphone bias; 0 leaves output floating.
// - Bits 2:1 select mid-rail divider: off, normal, standby, fast start.
// - Bit 0 of bias register enables reference bias for analogue functions.
// - Two read/write enable registers, all zero at reset; PLL and converters.
// - Bit 14 of function register enables the thermal sensor.
// - Bit 11 of function register enables the clock driven out on a pin.
// - Bits 9 and 8 enable left and right input paths.
// - Bits 7 to 4 enable the four input gain stages.
// - Any write to register zero returns every control register to default.
// - Reading register zero returns the fixed family code.
// - Each access carries an address and 16 data bits mapping one-to-one; here each AXI access carries 32 data bits, of which the low 16 are used.
`ifndef PMR_PARAMS_SVH
`define PMR_PARAMS_SVH
`define PMR_ADDR_W 8
`define PMR_IDX_W 6
`define PMR_REG_W 16
`define PMR_IDX_RESET_AND_IDENTITY 6'h00
`define PMR_IDX_BIAS 6'h01
`define PMR_IDX_FUNC 6'h02
`define PMR_BIAS_MASK 16'h0017
`define PMR_FUNC_MASK 16'hcbf3
`define PMR_REG_RST 16'h0000
`define PMR_FAMILY_DEF 16'h5a5a
`define PMR_BIT_MIC 4
`define PMR_MID_HI 2
`define PMR_MID_LO 1
`define PMR_BIT_REF 0
`define PMR_BIT_PLL 15
`define PMR_BIT_THERM 14
`define PMR_BIT_CLKOUT 11
`define PMR_BIT_LPATH 9
`define PMR_BIT_RPATH 8
`define PMR_BIT_LGAIN_B 7
`define PMR_BIT_LGAIN_A 6
`define PMR_BIT_RGAIN_B 5
`define PMR_BIT_RGAIN_A 4
`define PMR_BIT_LCONV 1
`define PMR_BIT_RCONV 0
`define PMR_RESP_OKAY 2'h0
`define PMR_RESP_DECERR 2'h3
`endif

/* hw/pmr_pkg.sv */
// Types shared by the power enable register block
`include "pmr_params.svh"
`default_nettype none
package pmr_pkg;
    typedef logic [`PMR_REG_W-1:0] pmr_word_t;

    typedef struct packed {
        logic pll_on;
        logic thermal_sensor_on;
        logic clock_out_on;
        logic left_path_on;
        logic right_path_on;
        logic left_pair_b_gain_on;
        logic left_pair_a_gain_on;
        logic right_pair_b_gain_on;
        logic right_pair_a_gain_on;
        logic left_converter_on;
        logic right_converter_on;
        logic mic_bias_on;
        logic [1:0] mid_rail_sel;
        logic ref_bias_on;
    } pmr_enables_s;

    typedef struct packed {
        logic aw_full;
        logic [`PMR_ADDR_W-1:0] aw_addr;
        logic w_full;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic awready;
        logic wready;
    } pmr_join_s;

    typedef struct packed {
        pmr_word_t value;
    } pmr_reg_s;

    typedef struct packed {
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic bvalid;
        logic [1:0] bresp;
    } pmr_slave_s;
endpackage
`default_nettype wire

/* hw/pmr_wr_join.sv */
// Holds write address and write data until both have arrived
`include "pmr_params.svh"
`default_nettype none
module pmr_wr_join (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // Write address channel
    input wire logic [`PMR_ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    // Write data channel
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // Joined write
    output logic pair_valid,
    output logic [`PMR_ADDR_W-1:0] pair_addr,
    output logic [31:0] pair_data,
    output logic [3:0] pair_strb,
    input wire logic pop
);
    pmr_pkg::pmr_join_s st;
    pmr_pkg::pmr_join_s next_st;

    always_comb begin
        next_st = st;
        if (pop) begin
            next_st.aw_full = 1'b0;
            next_st.w_full = 1'b0;
        end
        if (awvalid && st.awready) begin
            next_st.aw_full = 1'b1;
            next_st.aw_addr = awaddr;
        end
        if (wvalid && st.wready) begin
            next_st.w_full = 1'b1;
            next_st.w_data = wdata;
            next_st.w_strb = wstrb;
        end
        next_st.awready = !next_st.aw_full;
        next_st.wready = !next_st.w_full;
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            st <= '0;
            st.awready <= 1'b1;
            st.wready <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign awready = st.awready;
    assign wready = st.wready;
    assign pair_valid = st.aw_full && st.w_full;
    assign pair_addr = st.aw_addr;
    assign pair_data = st.w_data;
    assign pair_strb = st.w_strb;
endmodule
`default_nettype wire

/* hw/pmr_ctrl_reg.sv */
// One 16-bit enable register with byte lanes, writable mask and soft clear
`include "pmr_params.svh"
`default_nettype none
module pmr_ctrl_reg #(
    parameter pmr_pkg::pmr_word_t MASK = `PMR_BIAS_MASK
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // Update
    input wire logic wr_en,
    input wire logic soft_clr,
    input wire pmr_pkg::pmr_word_t wdata,
    input wire logic [1:0] wstrb,
    // Stored value
    output pmr_pkg::pmr_word_t value
);
    pmr_pkg::pmr_reg_s st;
    pmr_pkg::pmr_reg_s next_st;

    function automatic pmr_pkg::pmr_word_t merge(input pmr_pkg::pmr_word_t old,
                                                 input pmr_pkg::pmr_word_t nw,
                                                 input logic [1:0] strb);
        pmr_pkg::pmr_word_t res;
        res = old;
        for (int i = 0; i < 2; i++) begin
            if (strb[i]) begin
                res[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return res & MASK;
    endfunction

    always_comb begin
        next_st = st;
        if (wr_en) begin
            next_st.value = merge(st.value, wdata, wstrb);
        end
        if (soft_clr) begin
            next_st.value = `PMR_REG_RST;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            st.value <= `PMR_REG_RST;
        end else begin
            st <= next_st;
        end
    end

    assign value = st.value;
endmodule
`default_nettype wire

/* bench/tb.sv */
// Self-checking bench for the power enable register block
`include "pmr_params.svh"
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 100ps;

    // Value is arbitrary, not a real part code
    localparam logic [15:0] FAMILY = 16'h3c96;

    logic sys_clk;
    logic nrst;
    logic [`PMR_ADDR_W-1:0] s_axi_awaddr;
    logic s_axi_awvalid;
    logic s_axi_awready;
    logic [31:0] s_axi_wdata;
    logic [3:0] s_axi_wstrb;
    logic s_axi_wvalid;
    logic s_axi_wready;
    logic [1:0] s_axi_bresp;
    logic s_axi_bvalid;
    logic s_axi_bready;
    logic [`PMR_ADDR_W-1:0] s_axi_araddr;
    logic s_axi_arvalid;
    logic s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_rresp;
    logic s_axi_rvalid;
    logic s_axi_rready;
    pmr_pkg::pmr_enables_s enables;
    int num_errors = 0;
    int samples_checked = 0;
    int cycles = 0;
    logic [15:0] sh_b = 16'h0000;
    logic [15:0] sh_f = 16'h0000;

    pmr_regs #(.FAMILY_CODE(FAMILY)) i_dut (
        .sys_clk(sys_clk), .nrst(nrst),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .enables(enables)
    );

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            wrap_up();
        end
    end

    task automatic cmp_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cmp_resp(input string what, input logic [1:0] exp, input logic [1:0] got);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cmp_en(input pmr_pkg::pmr_enables_s exp);
        samples_checked++;
        if (enables !== exp) begin
            num_errors++;
            $display("BAD enables expected %h seen %h", exp, enables);
        end
    endtask

    // Expected enable levels from the two stored words
    function automatic pmr_pkg::pmr_enables_s exp_en(input logic [15:0] b, input logic [15:0] f);
        return {f[15], f[14], f[11], f[9], f[8], f[7:4], f[1:0], b[4], b[2:1], b[0]};
    endfunction

    // W is offered dly cycles after AW; enables must not move before W arrives
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                             input int dly, input pmr_pkg::pmr_enables_s old,
                             output logic [1:0] resp);
        int n;
        n = 0;
        @(posedge sys_clk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_wvalid <= (dly == 0);
        s_axi_bready <= 1'b1;
        forever begin
            @(posedge sys_clk);
            n++;
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (n == dly) s_axi_wvalid <= 1'b1;
            if (n <= dly) cmp_en(old);
            if (s_axi_bvalid === 1'b1) begin
                resp = s_axi_bresp;
                s_axi_bready <= 1'b0;
                break;
            end
        end
    endtask

    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge sys_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        forever begin
            @(posedge sys_clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1) begin
                d = s_axi_rdata;
                r = s_axi_rresp;
                s_axi_rready <= 1'b0;
                break;
            end
        end
    endtask

    // Write a register by index and track the expected stored words
    task automatic wreg(input int idx, input logic [31:0] d, input logic [3:0] s, input int dly);
        logic [1:0] r;
        logic [15:0] m;
        m = {{8{s[1]}}, {8{s[0]}}};
        axi_write(8'(idx * 4), d, s, dly, enables, r);
        if (idx == 0) begin
            sh_b = 16'h0000;
            sh_f = 16'h0000;
        end else if (idx == 1) begin
            sh_b = ((sh_b & ~m) | (d[15:0] & m)) & 16'h0017;
        end else if (idx == 2) begin
            sh_f = ((sh_f & ~m) | (d[15:0] & m)) & 16'hcbf3;
        end
        cmp_resp("bresp", (idx < 3) ? 2'h0 : 2'h3, r);
    endtask

    task automatic check_all();
        logic [31:0] d;
        logic [1:0] r;
        axi_read(8'h04, d, r);
        cmp_word("bias_reg", {16'h0000, sh_b}, d);
        cmp_resp("rresp_bias", 2'h0, r);
        axi_read(8'h08, d, r);
        cmp_word("func_reg", {16'h0000, sh_f}, d);
        cmp_resp("rresp_func", 2'h0, r);
        cmp_en(exp_en(sh_b, sh_f));
    endtask

    task automatic t_family();
        logic [31:0] d;
        logic [1:0] r;
        axi_read(8'h00, d, r);
        cmp_word("family_code", {16'h0000, FAMILY}, d);
        cmp_resp("rresp_family", 2'h0, r);
    endtask

    task automatic t_bias();
        for (int c = 0; c < 4; c++) begin
            wreg(1, {16'h0000, 11'h000, c[0], 1'b0, c[1:0], ~c[0]}, 4'b0011, 0);
            check_all();
        end
        wreg(1, 32'hffff_ffff, 4'b1111, 0);
        check_all();
    endtask

    task automatic t_func();
        int pos[11] = '{15, 14, 11, 9, 8, 7, 6, 5, 4, 1, 0};
        foreach (pos[i]) begin
            wreg(2, 32'h0000_0001 << pos[i], 4'b0011, 0);
            check_all();
        end
        wreg(2, 32'hffff_ffff, 4'b1111, 0);
        check_all();
    endtask

    task automatic t_lanes();
        wreg(2, 32'h0000_0000, 4'b0001, 0);
        check_all();
        wreg(2, 32'h0000_0000, 4'b1100, 0);
        check_all();
    endtask

    task automatic t_power_order();
        wreg(1, 32'h0000_0003, 4'b0011, 0);
        wreg(2, 32'h0000_0303, 4'b0011, 0);
        check_all();
        wreg(2, 32'h0000_0000, 4'b0011, 0);
        wreg(1, 32'h0000_0000, 4'b0011, 0);
        check_all();
    endtask

    task automatic t_hold();
        wreg(2, 32'h0000_0a5a, 4'b0011, 3);
        check_all();
        wreg(1, 32'h0000_0015, 4'b0011, 2);
        check_all();
    endtask

    task automatic t_soft_reset();
        wreg(0, 32'h0000_0000, 4'b0000, 0);
        check_all();
        t_family();
    endtask

    task automatic t_unmapped();
        logic [31:0] d;
        logic [1:0] r;
        wreg(3, 32'h0000_ffff, 4'b1111, 0);
        check_all();
        axi_read(8'h0c, d, r);
        cmp_word("unmapped_rdata", 32'h0000_0000, d);
        cmp_resp("unmapped_rresp", 2'h3, r);
    endtask

    initial begin
        nrst = 1'b0;
        s_axi_awaddr = '0;
        s_axi_awvalid = 1'b0;
        s_axi_wdata = '0;
        s_axi_wstrb = '0;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b0;
        s_axi_araddr = '0;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0;
        repeat (8) @(posedge sys_clk);
        nrst <= 1'b1;
        check_all();
        t_family();
        t_bias();
        t_func();
        t_lanes();
        t_power_order();
        t_hold();
        t_soft_reset();
        t_unmapped();
        wrap_up();
    end
endmodule
`default_nettype wire
